// ===== src/mcu_memory_map_pkg.sv
/*
  Constants for the program and data address decode of a 16-bit core:
  program map regions, configuration word slots and data space layout.
  Assumes a single core clock; used by mcu_memory_map only.
*/
package mcu_memory_map_pkg;
  // program space
  localparam int PROG_AW = 24;
  localparam int PC_W = 23;
  localparam int PC_STEP = 2;
  localparam int TABLE_PAGE_UPPER_BIT = 7;
  localparam logic [23:0] USER_TOP = 24'h7FFFFF;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [23:0] RESET_TARGET = 24'h000002;
  localparam logic [23:0] IVT_START = 24'h000004;
  localparam logic [23:0] IVT_END = 24'h0000FF;
  localparam logic [23:0] AIVT_START = 24'h000104;
  localparam logic [23:0] AIVT_END = 24'h0001FF;
  localparam logic [23:0] EEPROM_START = 24'h7FFE00;
  localparam logic [23:0] EEPROM_END = 24'h7FFFFF;
  localparam int EEPROM_WORDS = 256;
  localparam logic [23:0] CONFIG_START = 24'hF80000;
  localparam logic [23:0] CONFIG_END = 24'hF80010;
  localparam logic [23:0] CFG_BOOT = 24'hF80000;
  localparam logic [23:0] CFG_GENERAL = 24'hF80004;
  localparam logic [23:0] CFG_OSC_SELECT = 24'hF80006;
  localparam logic [23:0] CFG_OSC = 24'hF80008;
  localparam logic [23:0] CFG_WATCHDOG = 24'hF8000A;
  localparam logic [23:0] CFG_POWER_ON = 24'hF8000C;
  localparam logic [23:0] CFG_DEBUG = 24'hF8000E;
  localparam logic [23:0] CFG_DEEP_SLEEP = 24'hF80010;
  // data space
  localparam int DATA_AW = 16;
  localparam int WINDOW_BIT = 15;
  localparam int NEAR_BITS = 13;
  localparam int RAM_WORDS = 1024;
  localparam int WREG_COUNT = 16;
  localparam logic [15:0] WREG_TOP = 16'h001F;
  localparam logic [15:0] SFR_TOP = 16'h07FF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam logic [15:0] RAM_TOP = 16'h0FFF;
  localparam logic [15:0] NEAR_TOP = 16'h1FFF;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [1:0] {
    ADDR_INDIRECT, ADDR_NEAR, ADDR_FULL
  } addr_mode_type;

  typedef enum logic [2:0] {
    CW_BOOT, CW_GENERAL, CW_OSC_SELECT, CW_OSC,
    CW_WATCHDOG, CW_POWER_ON, CW_DEBUG, CW_DEEP_SLEEP
  } config_word_type;
endpackage

// ===== src/mcu_memory_map.sv
/*
  Program space address former and decoder, plus the byte-addressed data
  space: working registers, data RAM, byte lanes and misalignment traps.
  Assumes the core's address generators drive requests synchronously.
*/
// Operation
// - program address is 24 bits, from 23-bit PC or table/window remap
// - user access limited to 000000h..7FFFFFh
// - table ops with page bit 7 reach configuration and ID space
// - even address is lower word, odd is upper word
// - PC stays even and steps by two
// - execution starts at 000000h, jump target held at 000002h
// - two vector tables at 000004h-0000FFh and 000104h-0001FFh
// - 256-word EEPROM window at 7FFE00..7FFFFF via table ops
// - eight configuration words at even addresses F80000..F80010
// - data addresses are 16-bit byte addresses, 64 Kbytes
// - bit 15 clear hits memory, set routes to program window
// - 1024 RAM words; unimplemented reads return zero
// - low byte at even address, high byte at odd
// - post-increment pointer steps 1 for byte, 2 for word
// - byte read selects by bit 0 onto low lane
// - shared word decode, separate byte write enables
// - odd word access traps; read completes in the same cycle as the trap
// - misaligned word write is suppressed, then trap
// - byte load into working register keeps high byte
// - sign-extend and zero-extend of working register low byte
// - near region 0000h..1FFFh reached by 13-bit direct field
// - 16-bit direct field reaches whole data space
// - window enable bit gates program visibility in data space
// - register area 0000h..07FFh, unused addresses read zero
`timescale 1ns/100ps
module mcu_memory_map (
  input wire logic clk,
  input wire logic rst,
  input wire logic pcLoad,
  input wire logic [22:0] pcTarget,
  input wire logic pcAdvance,
  input wire logic pcRetreat,
  output logic [22:0] pcAddress,
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [7:0] table_page_select,
  input wire logic [15:0] tableOffset,
  output logic [23:0] progAddress,
  output logic progUpperWord,
  output logic progFault,
  output logic resetVectorHit,
  output logic vectorTableHit,
  output logic eepromHit,
  output logic [7:0] eepromIndex,
  output logic configHit,
  output logic [2:0] configSelect,
  input wire logic dataReq,
  input wire logic dataWrite,
  input wire logic dataByte,
  input wire logic [1:0] addrMode,
  input wire logic [15:0] pointerValue,
  input wire logic [15:0] directField,
  input wire logic [15:0] writeData,
  input wire logic program_space_window,
  input wire logic [15:0] windowData,
  output logic [15:0] operand_byte_address,
  output logic [15:0] nextPointer,
  output logic windowRead,
  output logic [15:0] readData,
  output logic readValid,
  output logic addressErrorTrap,
  input wire logic regLoad,
  input wire logic regLoadByte,
  input wire logic [3:0] regSel,
  input wire logic [15:0] loadData,
  input wire logic sign_extend_op,
  input wire logic zero_extend_op
);

  ////////////////////////////////////////////////////////////////////////
  // program counter

  always_ff @(posedge clk) begin
    if (rst) begin
      pcAddress <= mcu_memory_map_pkg::RESET_VECTOR[22:0];
    end else if (pcLoad) begin
      pcAddress <= {pcTarget[22:1], 1'b0};
    end else if (pcAdvance) begin
      pcAddress <= pcAddress + 23'(mcu_memory_map_pkg::PC_STEP);
    end else if (pcRetreat) begin
      pcAddress <= pcAddress - 23'(mcu_memory_map_pkg::PC_STEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program address forming and region decode

  logic tableOp;
  logic [23:0] next_progAddress;
  logic [2:0] next_configSelect;
  logic next_configHit;

  assign tableOp = table_read_op | table_write_op;
  // window remap keeps the top bit clear, so it never leaves user space
  always_comb begin
    if (tableOp) begin
      next_progAddress = {table_page_select, tableOffset};
    end else if (windowRead) begin
      next_progAddress = {9'h000, operand_byte_address[14:0]};
    end else begin
      next_progAddress = {1'b0, pcAddress};
    end
  end

  always_comb begin
    next_configHit = tableOp;
    next_configSelect = mcu_memory_map_pkg::CW_BOOT;
    unique case (next_progAddress)
      mcu_memory_map_pkg::CFG_BOOT:
        next_configSelect = mcu_memory_map_pkg::CW_BOOT;
      mcu_memory_map_pkg::CFG_GENERAL:
        next_configSelect = mcu_memory_map_pkg::CW_GENERAL;
      mcu_memory_map_pkg::CFG_OSC_SELECT:
        next_configSelect = mcu_memory_map_pkg::CW_OSC_SELECT;
      mcu_memory_map_pkg::CFG_OSC:
        next_configSelect = mcu_memory_map_pkg::CW_OSC;
      mcu_memory_map_pkg::CFG_WATCHDOG:
        next_configSelect = mcu_memory_map_pkg::CW_WATCHDOG;
      mcu_memory_map_pkg::CFG_POWER_ON:
        next_configSelect = mcu_memory_map_pkg::CW_POWER_ON;
      mcu_memory_map_pkg::CFG_DEBUG:
        next_configSelect = mcu_memory_map_pkg::CW_DEBUG;
      mcu_memory_map_pkg::CFG_DEEP_SLEEP:
        next_configSelect = mcu_memory_map_pkg::CW_DEEP_SLEEP;
      default:
        next_configHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      progAddress <= 24'h000000;
      progUpperWord <= 1'b0;
      progFault <= 1'b0;
      resetVectorHit <= 1'b0;
      vectorTableHit <= 1'b0;
      eepromHit <= 1'b0;
      eepromIndex <= 8'h00;
      configHit <= 1'b0;
      configSelect <= 3'h0;
    end else begin
      progAddress <= next_progAddress;
      progUpperWord <= next_progAddress[0];
      // upper half only for table ops with the page bit set
      progFault <= (next_progAddress > mcu_memory_map_pkg::USER_TOP) &&
        !(tableOp && table_page_select[
          mcu_memory_map_pkg::TABLE_PAGE_UPPER_BIT]);
      resetVectorHit <= next_progAddress <=
        mcu_memory_map_pkg::RESET_TARGET;
      vectorTableHit <=
        (next_progAddress >= mcu_memory_map_pkg::IVT_START &&
         next_progAddress <= mcu_memory_map_pkg::IVT_END) ||
        (next_progAddress >= mcu_memory_map_pkg::AIVT_START &&
         next_progAddress <= mcu_memory_map_pkg::AIVT_END);
      eepromHit <= tableOp &&
        next_progAddress >= mcu_memory_map_pkg::EEPROM_START &&
        next_progAddress <= mcu_memory_map_pkg::EEPROM_END;
      eepromIndex <= next_progAddress[8:1];
      configHit <= next_configHit;
      configSelect <= next_configSelect;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data space decode

  logic inWindow;
  logic inWreg;
  logic inRam;
  logic misaligned;
  logic doWrite;
  logic [1:0] laneWrite;
  logic [9:0] ramIndex;
  logic [15:0] readWord;
  logic [15:0] ram [mcu_memory_map_pkg::RAM_WORDS];
  logic [15:0] wreg [mcu_memory_map_pkg::WREG_COUNT];

  always_comb begin
    unique case (mcu_memory_map_pkg::addr_mode_type'(addrMode))
      mcu_memory_map_pkg::ADDR_NEAR:
        operand_byte_address = {3'h0, directField[12:0]};
      mcu_memory_map_pkg::ADDR_FULL:
        operand_byte_address = directField;
      default:
        operand_byte_address = pointerValue;
    endcase
  end

  assign nextPointer = pointerValue + (dataByte ?
    mcu_memory_map_pkg::BYTE_STEP : mcu_memory_map_pkg::WORD_STEP);
  assign inWindow = operand_byte_address[
    mcu_memory_map_pkg::WINDOW_BIT];
  assign inWreg = operand_byte_address <= mcu_memory_map_pkg::WREG_TOP;
  assign inRam = operand_byte_address >= mcu_memory_map_pkg::RAM_BASE &&
    operand_byte_address <= mcu_memory_map_pkg::RAM_TOP;
  assign ramIndex = operand_byte_address[10:1];
  assign misaligned = !dataByte && operand_byte_address[0];
  assign windowRead = dataReq && !dataWrite && inWindow &&
    program_space_window;
  assign doWrite = dataReq && dataWrite && !misaligned;
  // one word decode, a write line per byte: even byte is the low lane
  assign laneWrite = dataByte ? (operand_byte_address[0] ? 2'b10 : 2'b01)
    : 2'b11;

  always_comb begin
    if (inWreg) begin
      readWord = wreg[operand_byte_address[4:1]];
    end else if (inRam) begin
      readWord = ram[ramIndex];
    end else if (inWindow && program_space_window) begin
      readWord = windowData;
    end else begin
      readWord = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage: RAM and working registers

  always_ff @(posedge clk) begin
    if (doWrite && inRam) begin
      if (laneWrite[0]) begin
        ram[ramIndex][7:0] <= dataByte ? writeData[7:0]
          : writeData[7:0];
      end
      if (laneWrite[1]) begin
        ram[ramIndex][15:8] <= dataByte ? writeData[7:0]
          : writeData[15:8];
      end
    end
  end

  // a register load in the same cycle as a bus write to it wins
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < mcu_memory_map_pkg::WREG_COUNT; i++) begin
        wreg[i] <= 16'h0000;
      end
    end else begin
      if (doWrite && inWreg) begin
        if (laneWrite[0]) begin
          wreg[operand_byte_address[4:1]][7:0] <= writeData[7:0];
        end
        if (laneWrite[1]) begin
          wreg[operand_byte_address[4:1]][15:8] <= dataByte ?
            writeData[7:0] : writeData[15:8];
        end
      end
      if (sign_extend_op) begin
        wreg[regSel][15:8] <= {8{wreg[regSel][7]}};
      end else if (zero_extend_op) begin
        wreg[regSel][15:8] <= 8'h00;
      end
      if (regLoad) begin
        wreg[regSel][7:0] <= loadData[7:0];
        if (!regLoadByte) begin
          wreg[regSel][15:8] <= loadData[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read return and trap

  always_ff @(posedge clk) begin
    if (rst) begin
      readData <= 16'h0000;
      readValid <= 1'b0;
    end else begin
      // a misaligned read still completes, the trap is raised in the same cycle
      readValid <= dataReq && !dataWrite;
      if (dataReq && !dataWrite) begin
        readData <= dataByte ? {8'h00, operand_byte_address[0] ?
          readWord[15:8] : readWord[7:0]} : readWord;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addressErrorTrap <= 1'b0;
    end else begin
      addressErrorTrap <= dataReq && misaligned;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_pc_reset_start: assert property (
    $fell(rst) |-> pcAddress == 23'h000000)
    else $error("pc not at reset vector after reset");
  a_pc_step_two: assert property (
    pcAdvance && !pcLoad |=> pcAddress == $past(pcAddress) + 23'h000002)
    else $error("pc did not advance by two");
  a_pc_even_word: assert property (pcAddress[0] == 1'b0)
    else $error("pc left the lower word");
  a_trap_misalign: assert property (
    dataReq && !dataByte && operand_byte_address[0] |=>
    addressErrorTrap ##1 !addressErrorTrap || $past(dataReq))
    else $error("odd word access without trap");
  a_write_suppress: assert property (
    dataReq && dataWrite && misaligned && inRam |=>
    ram[$past(ramIndex)] == $past(ram[ramIndex]))
    else $error("misaligned write reached memory");
  a_byte_low_lane: assert property (
    dataReq && !dataWrite && dataByte |=> readData[15:8] == 8'h00)
    else $error("byte read left data on high lane");
  a_unimpl_zero: assert property (
    dataReq && !dataWrite && !inWreg && !inRam && !inWindow |=>
    readData == 16'h0000 && readValid)
    else $error("unimplemented read not zero");
  a_window_off: assert property (
    dataReq && !dataWrite && inWindow && !program_space_window |->
    !windowRead ##1 readData == 16'h0000)
    else $error("window visible while disabled");
  a_wreg_byte_load: assert property (
    regLoad && regLoadByte && !sign_extend_op && !zero_extend_op &&
    !(doWrite && inWreg) |=>
    wreg[$past(regSel)][15:8] == $past(wreg[regSel][15:8]))
    else $error("byte load changed high byte");
  a_near_limit: assert property (
    addrMode == 2'h1 |->
    operand_byte_address <= mcu_memory_map_pkg::NEAR_TOP)
    else $error("near address beyond near region");
  a_eeprom_window: assert property (
    eepromHit |->
    progAddress >= mcu_memory_map_pkg::EEPROM_START && !progFault)
    else $error("eeprom hit outside its window");

  c_misalign_write: cover property (dataReq && dataWrite && misaligned);
  c_odd_byte_read: cover property (
    dataReq && !dataWrite && dataByte && operand_byte_address[0]);
  c_config_word: cover property (configHit);
  c_window_read: cover property (windowRead);

endmodule // mcu_memory_map

// ===== sim/core_model.sv
/*
  Behavioural model of the core's data address generator: it presents one
  data request per call and holds it for a whole clock cycle.
  Assumes its tasks are called just after a rising edge of clk.
*/
`timescale 1ns/100ps
module core_model (
  input wire logic clk,
  output logic dataReq,
  output logic dataWrite,
  output logic dataByte,
  output logic [1:0] addrMode,
  output logic [15:0] pointerValue,
  output logic [15:0] directField,
  output logic [15:0] writeData
);
  initial begin
    dataReq = 1'b0;
    dataWrite = 1'b0;
    dataByte = 1'b0;
    addrMode = 2'h0;
    pointerValue = 16'h0000;
    directField = 16'hFFFF;
    writeData = 16'h5555;
  end

  //////////////////////////////////////////////////////////////////////////
  // request stays up so a following call can run back to back
  task automatic access(input logic w, input logic b, input logic [1:0] m,
      input logic [15:0] a, input logic [15:0] d);
    dataReq = 1'b1;
    dataWrite = w;
    dataByte = b;
    addrMode = m;
    // mode 3 falls back to the pointer, like mode 0
    pointerValue = (m[0] == m[1]) ? a : ~a;
    // near field is 13 bits: junk above it must be ignored
    directField = (m == 2'h1) ? (a | 16'hE000) : (m == 2'h2) ? a : ~a;
    writeData = w ? d : ~d;
    @(posedge clk);
    #1;
  endtask

  // released address and data lines show inverted values; write, byte and mode lines keep the stale request
  task automatic idle();
    dataReq = 1'b0;
    pointerValue = ~pointerValue;
    directField = ~directField;
    writeData = ~writeData;
  endtask
endmodule // core_model

// ===== sim/test_mcu_memory_map.sv
/*
  Self-checking bench for mcu_memory_map: program decode, PC, data space
  and working registers. Assumes core_model drives the data request pins.
*/
`timescale 1ns/100ps
module test_mcu_memory_map;
  logic clk, rst, pcLoad, pcAdvance, pcRetreat, table_read_op;
  logic table_write_op, program_space_window, regLoad, regLoadByte;
  logic sign_extend_op, zero_extend_op, dataReq, dataWrite, dataByte;
  logic progUpperWord, progFault, resetVectorHit, vectorTableHit, eepromHit;
  logic configHit, windowRead, readValid, addressErrorTrap;
  logic [22:0] pcTarget, pcAddress;
  logic [7:0] table_page_select, eepromIndex;
  logic [15:0] tableOffset, pointerValue, directField, writeData, windowData;
  logic [15:0] operand_byte_address, nextPointer, readData, loadData, a, d;
  logic [23:0] progAddress;
  logic [2:0] configSelect;
  logic [1:0] addrMode;
  logic [3:0] regSel;
  logic [16:0] notes[$];
  logic [16:0] n;
  logic [15:0] mem [1024];
  integer seed, miscompares, checkCount, cycles, k;

  mcu_memory_map mcu_memory_map_i (.clk(clk), .rst(rst), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .pcAdvance(pcAdvance), .pcRetreat(pcRetreat),
    .pcAddress(pcAddress), .table_read_op(table_read_op),
    .table_write_op(table_write_op), .table_page_select(table_page_select),
    .tableOffset(tableOffset), .progAddress(progAddress),
    .progUpperWord(progUpperWord), .progFault(progFault),
    .resetVectorHit(resetVectorHit), .vectorTableHit(vectorTableHit),
    .eepromHit(eepromHit), .eepromIndex(eepromIndex), .configHit(configHit),
    .configSelect(configSelect), .dataReq(dataReq), .dataWrite(dataWrite),
    .dataByte(dataByte), .addrMode(addrMode), .pointerValue(pointerValue),
    .directField(directField), .writeData(writeData),
    .program_space_window(program_space_window), .windowData(windowData),
    .operand_byte_address(operand_byte_address), .nextPointer(nextPointer),
    .windowRead(windowRead), .readData(readData), .readValid(readValid),
    .addressErrorTrap(addressErrorTrap), .regLoad(regLoad),
    .regLoadByte(regLoadByte), .regSel(regSel), .loadData(loadData),
    .sign_extend_op(sign_extend_op), .zero_extend_op(zero_extend_op));

  core_model core_model_i (.clk(clk), .dataReq(dataReq),
    .dataWrite(dataWrite), .dataByte(dataByte), .addrMode(addrMode),
    .pointerValue(pointerValue), .directField(directField),
    .writeData(writeData));

  always #2.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checkCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic b, input logic [1:0] m, input logic [15:0] ad,
      input logic [15:0] e, input logic t);
    notes.push_back({t, e});
    core_model_i.access(1'b0, b, m, ad, 16'h0000);
  endtask

  // table access; flags are {fault, upper, reset, vector, eeprom, config}
  task automatic tp(input logic r, input logic [7:0] pg,
      input logic [15:0] off, input logic [5:0] f);
    table_read_op = r;
    table_write_op = ~r;
    table_page_select = pg;
    tableOffset = off;
    cyc();
    chk(progAddress, {pg, off});
    chk(24'({progFault, progUpperWord, resetVectorHit, vectorTableHit,
      eepromHit, configHit}), 24'(f));
  endtask

  // a result note is taken off the queue whenever a read answers
  always @(posedge clk) begin
    if (readValid === 1'b1) begin
      if (notes.size() == 0) chk(24'h1, 24'h0);
      else begin
        n = notes.pop_front();
        chk(24'(readData), 24'(n[15:0]));
        chk(24'(addressErrorTrap), 24'(n[16]));
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 24;
    miscompares = 0;
    checkCount = 0;
    cycles = 0;
    clk = 1'b0;
    rst = 1'b1;
    pcLoad = 1'b0;
    pcTarget = 23'h0;
    pcAdvance = 1'b0;
    pcRetreat = 1'b0;
    table_read_op = 1'b0;
    table_write_op = 1'b0;
    table_page_select = 8'h00;
    tableOffset = 16'h0;
    program_space_window = 1'b0;
    windowData = 16'h0;
    regLoad = 1'b0;
    regLoadByte = 1'b0;
    regSel = 4'h0;
    loadData = 16'h0;
    sign_extend_op = 1'b0;
    zero_extend_op = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    cyc();
    chk(24'(pcAddress), 24'h0);
    chk(24'(resetVectorHit), 24'h1);
    pcAdvance = 1'b1;
    cyc();
    cyc();
    chk(24'(pcAddress), 24'h4);
    pcAdvance = 1'b0;
    pcRetreat = 1'b1;
    cyc();
    chk(24'(pcAddress), 24'h2);
    {pcLoad, pcAdvance, pcTarget} = {2'b11, 23'h12345};
    cyc();
    chk(24'(pcAddress), 24'h012344);
    {pcLoad, pcAdvance, pcRetreat} = 3'b000;
    for (k = 0; k < 8; k++) begin
      tp(k[0], 8'hF8, (k == 0) ? 16'h0 : 16'(2 + 2 * k), 6'b000001);
      chk(24'(configSelect), 24'(k));
    end
    tp(1'b1, 8'hF8, 16'h0002, 6'b000000);
    tp(1'b1, 8'h80, 16'h0000, 6'b000000);
    a = 16'($random(seed) & 8'hFF);
    tp(1'b0, 8'h7F, 16'hFE00 + (a << 1), 6'b000010);
    chk(24'(eepromIndex), 24'(a[7:0]));
    tp(1'b1, 8'h7F, 16'hFFFF, 6'b010010);
    tp(1'b1, 8'h7F, 16'hFDFE, 6'b000000);
    tp(1'b1, 8'h00, 16'h0002, 6'b001000);
    tp(1'b1, 8'h00, 16'h0003, 6'b010000);
    tp(1'b1, 8'h00, 16'h0004, 6'b000100);
    tp(1'b1, 8'h00, 16'h00FF, 6'b010100);
    tp(1'b1, 8'h00, 16'h0100, 6'b000000);
    tp(1'b1, 8'h00, 16'h0104, 6'b000100);
    tp(1'b0, 8'h00, 16'h01FF, 6'b010100);
    tp(1'b0, 8'h00, 16'h0200, 6'b000000);
    table_read_op = 1'b0;
    table_write_op = 1'b0;
    for (k = 0; k < 6; k++) begin
      a = 16'h0800 | (16'($random(seed)) & 16'h07FE);
      d = 16'($random(seed));
      mem[a[10:1]] = d;
      core_model_i.access(1'b1, 1'b0, 2'(k % 3), a, d);
      rd(1'b0, 2'((k + 1) % 3), a, mem[a[10:1]], 1'b0);
      chk(24'(operand_byte_address), 24'(a));
    end
    core_model_i.access(1'b1, 1'b0, 2'h0, a, 16'h0000);
    core_model_i.access(1'b1, 1'b1, 2'h0, a + 16'h1, 16'hF05A);
    core_model_i.access(1'b1, 1'b1, 2'h2, a, 16'h123C);
    rd(1'b0, 2'h0, a, 16'h5A3C, 1'b0);
    core_model_i.access(1'b1, 1'b0, 2'h0, a + 16'h1, 16'hFFFF);
    chk(24'(addressErrorTrap), 24'h1);
    rd(1'b0, 2'h0, a, 16'h5A3C, 1'b0);
    rd(1'b1, 2'h0, a + 16'h1, 16'h005A, 1'b0);
    chk(24'(nextPointer), 24'(a + 16'h2));
    rd(1'b1, 2'h0, a, 16'h003C, 1'b0);
    chk(24'(nextPointer), 24'(a + 16'h1));
    rd(1'b0, 2'h0, a + 16'h1, 16'h5A3C, 1'b1);
    chk(24'(nextPointer), 24'(a + 16'h3));
    rd(1'b0, 2'h2, 16'h0400, 16'h0000, 1'b0);
    rd(1'b0, 2'h2, 16'h1000, 16'h0000, 1'b0);
    rd(1'b1, 2'h2, 16'h7FFF, 16'h0000, 1'b0);
    rd(1'b0, 2'h2, 16'h8002, 16'h0000, 1'b0);
    chk(24'(windowRead), 24'h0);
    windowData = 16'($random(seed));
    program_space_window = 1'b1;
    rd(1'b0, 2'h2, 16'h8002, windowData, 1'b0);
    chk(24'(windowRead), 24'h1);
    chk(progAddress, 24'h000002);
    {regLoad, regSel, loadData} = {1'b1, 4'h3, 16'h1234};
    rd(1'b0, 2'h0, 16'h0006, 16'h0000, 1'b0);
    {regLoadByte, loadData} = {1'b1, 16'hABCD};
    rd(1'b0, 2'h0, 16'h0006, 16'h1234, 1'b0);
    {regLoad, sign_extend_op} = 2'b01;
    rd(1'b0, 2'h0, 16'h0006, 16'h12CD, 1'b0);
    {sign_extend_op, zero_extend_op} = 2'b01;
    rd(1'b0, 2'h0, 16'h0006, 16'hFFCD, 1'b0);
    zero_extend_op = 1'b0;
    rd(1'b0, 2'h3, 16'h0006, 16'h00CD, 1'b0);
    core_model_i.idle();
    // reset again mid-run: pc and working registers must clear
    rst = 1'b1;
    repeat (2) cyc();
    rst = 1'b0;
    cyc();
    chk(24'(pcAddress), 24'h0);
    rd(1'b0, 2'h0, 16'h0006, 16'h0000, 1'b0);
    core_model_i.idle();
    repeat (3) cyc();
    chk(24'(notes.size()), 24'h0);
    report_and_stop();
  end
endmodule // test_mcu_memory_map
